/* File: hw/alu_compare_execute.sv */
// Purpose: execute conditional adds, and, shifts and compares
// Assumes: one instruction per cycle, operands from local registers
// Notes: register file and true/false flag live here
`timescale 1ns/100ps

module alu_compare_execute (
    input wire logic clock,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic load_en,
    input wire logic [3:0] load_index,
    input wire logic [31:0] load_data,
    input wire logic [3:0] read_index,
    output logic [31:0] read_data,
    output logic true_false_flag,
    output logic done,
    output logic illegal
);
    import ace_pkg::*;

    // ============================================================
    // field extraction and decode
    // ============================================================
    ace_fields_t fld;
    ace_op_t dec_op;
    ace_alu_out_t alu_res;
    logic [31:0] reg_file [ACE_REG_N];
    logic tf_reg;
    logic [31:0] read_data_reg;
    logic done_reg;
    logic illegal_reg;

    assign fld = instr;
    wire logic [3:0] dst_idx = fld.dst;
    wire logic [3:0] src_idx = fld.low;
    wire logic [7:0] unsigned_imm_eight = {instr[11:8], instr[3:0]};
    wire logic is_andi = instr[15:12] == ACE_NIB_ANDI;

    assign dec_op = is_andi ? ACE_OP_ANDI :
        (fld.opcode == ACE_OPC_ADDIT) ? ACE_OP_ADDIT :
        (fld.opcode == ACE_OPC_ADDT) ? ACE_OP_ADDT :
        (fld.opcode == ACE_OPC_AND) ? ACE_OP_AND :
        (fld.opcode == ACE_OPC_ASR) ? ACE_OP_ASR :
        (fld.opcode == ACE_OPC_ASRI) ? ACE_OP_ASRI :
        (fld.opcode == ACE_OPC_CMPEQ) ? ACE_OP_CMPEQ :
        (fld.opcode == ACE_OPC_CMPEQI) ? ACE_OP_CMPEQI :
        (fld.opcode == ACE_OPC_CMPGT) ? ACE_OP_CMPGT :
        (fld.opcode == ACE_OPC_CMPGTI) ? ACE_OP_CMPGTI :
        (fld.opcode == ACE_OPC_CMPHS) ? ACE_OP_CMPHS :
        (fld.opcode == ACE_OPC_CMPLS) ? ACE_OP_CMPLS :
        (fld.opcode == ACE_OPC_CMPLT) ? ACE_OP_CMPLT :
        (fld.opcode == ACE_OPC_CMPLTI) ? ACE_OP_CMPLTI : ACE_OP_NONE;

    // operand read and write qualifiers
    wire logic [31:0] d_val = reg_file[dst_idx];
    wire logic [31:0] s_val = reg_file[src_idx];
    wire logic go = instr_valid && (dec_op != ACE_OP_NONE);
    wire logic bad = instr_valid && (dec_op == ACE_OP_NONE);
    wire logic res_wr = go && alu_res.wr;
    wire logic flag_wr = go && alu_res.tf_wr;
    wire logic host_wr = load_en && !instr_valid;

    // ============================================================
    // compute unit
    // ============================================================
    // adds gated by flag inside the unit
    ace_alu u_alu (
        .op(dec_op),
        .d_val(d_val),
        .s_val(s_val),
        .low(fld.low),
        .unsigned_imm_eight(unsigned_imm_eight),
        .tf_in(tf_reg),
        .res(alu_res)
    );

    // ============================================================
    // register file
    // ============================================================
    // one writable entry per register; instruction beats load port
    for (genvar g = 0; g < ACE_REG_N; g++) begin : g_reg
        wire logic hit_exec = res_wr && (dst_idx == 4'(g));
        wire logic hit_load = host_wr && (load_index == 4'(g));
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                reg_file[g] <= ACE_REG_RESET;
            end else if (hit_exec) begin
                reg_file[g] <= alu_res.value;
            end else if (hit_load) begin
                reg_file[g] <= load_data;
            end
        end
    end

    // ============================================================
    // flag and outputs
    // ============================================================
    // flag written only by compares
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tf_reg <= ACE_TF_RESET;
        end else if (flag_wr) begin
            tf_reg <= alu_res.tf;
        end
    end

    // registered read port and status pulses
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            read_data_reg <= ACE_REG_RESET;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            read_data_reg <= reg_file[read_index];
            done_reg <= go;
            illegal_reg <= bad;
        end
    end

    assign read_data = read_data_reg;
    assign true_false_flag = tf_reg;
    assign done = done_reg;
    assign illegal = illegal_reg;

    // ============================================================
    // checks
    // ============================================================
    default clocking ck @(posedge clock); endclocking
    default disable iff (!nrst);

    // independent reference values for the checks
    wire logic [31:0] chk_simm = {{28{fld.low[3]}}, fld.low};
    wire logic [31:0] chk_sum_imm = d_val + chk_simm;
    wire logic [31:0] chk_sum_reg = d_val + s_val;
    wire logic [31:0] chk_and = d_val & s_val;
    wire logic [31:0] chk_andi = d_val & {24'h000000, unsigned_imm_eight};
    wire logic [31:0] chk_sign = {32{d_val[31]}};
    wire logic chk_lt = $signed(d_val) < $signed(s_val);
    wire logic chk_cmp = (dec_op >= ACE_OP_CMPEQ);
    wire logic [5:0] chk_amt = s_val[5:0];
    // shift references built from a logical shift plus a sign mask
    wire logic [31:0] chk_fill = ~(32'hFFFF_FFFF >> chk_amt[4:0]);
    wire logic [31:0] chk_asr = (d_val >> chk_amt[4:0]) | (chk_sign & chk_fill);
    wire logic [31:0] chk_fill_imm = ~(32'hFFFF_FFFF >> fld.low);
    wire logic [31:0] chk_asri = (d_val >> fld.low) | (chk_sign & chk_fill_imm);
    // signed order through a flipped sign bit and an unsigned compare
    wire logic [31:0] chk_d_bias = {~d_val[31], d_val[30:0]};
    wire logic [31:0] chk_s_bias = {~s_val[31], s_val[30:0]};
    wire logic [31:0] chk_i_bias = {~chk_simm[31], chk_simm[30:0]};
    wire logic chk_eqi = d_val == chk_simm;
    wire logic chk_gt = chk_d_bias > chk_s_bias;
    wire logic chk_gti = chk_d_bias > chk_i_bias;
    wire logic chk_lti = chk_d_bias < chk_i_bias;
    wire logic chk_hs = !(d_val < s_val);
    wire logic chk_ls = !(d_val > s_val);

    sequence s_issue(ace_op_t o);
        instr_valid && dec_op == o;
    endsequence

    property p_addit;
        s_issue(ACE_OP_ADDIT) and tf_reg |=> reg_file[$past(dst_idx)] == $past(chk_sum_imm);
    endproperty
    a_addit: assert property (p_addit) else $error("add-imm-if-true wrong sum");

    property p_addit_hold;
        s_issue(ACE_OP_ADDIT) and !tf_reg |=> reg_file[$past(dst_idx)] == $past(d_val);
    endproperty
    a_addit_hold: assert property (p_addit_hold) else $error("add-imm wrote while false");

    property p_addt_hold;
        s_issue(ACE_OP_ADDT) and !tf_reg |=> reg_file[$past(dst_idx)] == $past(d_val);
    endproperty
    a_addt_hold: assert property (p_addt_hold) else $error("add-if-true wrote while false");

    property p_addt;
        s_issue(ACE_OP_ADDT) and tf_reg |=> reg_file[$past(dst_idx)] == $past(chk_sum_reg);
    endproperty
    a_addt: assert property (p_addt) else $error("add-if-true wrong sum");

    property p_and;
        s_issue(ACE_OP_AND) |=> reg_file[$past(dst_idx)] == $past(chk_and);
    endproperty
    a_and: assert property (p_and) else $error("and result wrong");

    property p_andi;
        s_issue(ACE_OP_ANDI) |=> reg_file[$past(dst_idx)] == $past(chk_andi);
    endproperty
    a_andi: assert property (p_andi) else $error("and-immediate result wrong");

    property p_asr_big;
        s_issue(ACE_OP_ASR) and chk_amt > ACE_SHAMT_MAX
            |=> reg_file[$past(dst_idx)] == $past(chk_sign);
    endproperty
    a_asr_big: assert property (p_asr_big) else $error("oversize shift not sign fill");

    property p_asr_zero;
        s_issue(ACE_OP_ASR) and chk_amt == 6'h00 |=> reg_file[$past(dst_idx)] == $past(d_val);
    endproperty
    a_asr_zero: assert property (p_asr_zero) else $error("zero shift changed value");

    property p_cmpeq;
        s_issue(ACE_OP_CMPEQ) |=> tf_reg == ($past(d_val) == $past(s_val));
    endproperty
    a_cmpeq: assert property (p_cmpeq) else $error("equal compare flag wrong");

    property p_cmplt;
        s_issue(ACE_OP_CMPLT) |=> tf_reg == $past(chk_lt);
    endproperty
    a_cmplt: assert property (p_cmplt) else $error("signed less-than flag wrong");

    property p_flag_hold;
        !(instr_valid && chk_cmp && dec_op != ACE_OP_NONE) |=> $stable(tf_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag changed without compare");

    property p_asr_small;
        s_issue(ACE_OP_ASR) and chk_amt <= ACE_SHAMT_MAX |=> reg_file[$past(dst_idx)] == $past(chk_asr);
    endproperty
    a_asr_small: assert property (p_asr_small) else $error("dynamic shift wrong");

    property p_asri;
        s_issue(ACE_OP_ASRI) |=> reg_file[$past(dst_idx)] == $past(chk_asri);
    endproperty
    a_asri: assert property (p_asri) else $error("static shift wrong");

    property p_cmpeqi;
        s_issue(ACE_OP_CMPEQI) |=> tf_reg == $past(chk_eqi);
    endproperty
    a_cmpeqi: assert property (p_cmpeqi) else $error("imm equal flag wrong");

    property p_cmpgt;
        s_issue(ACE_OP_CMPGT) |=> tf_reg == $past(chk_gt);
    endproperty
    a_cmpgt: assert property (p_cmpgt) else $error("signed greater flag wrong");

    property p_cmpgti;
        s_issue(ACE_OP_CMPGTI) |=> tf_reg == $past(chk_gti);
    endproperty
    a_cmpgti: assert property (p_cmpgti) else $error("imm greater flag wrong");

    property p_cmphs;
        s_issue(ACE_OP_CMPHS) |=> tf_reg == $past(chk_hs);
    endproperty
    a_cmphs: assert property (p_cmphs) else $error("higher-same flag wrong");

    property p_cmpls;
        s_issue(ACE_OP_CMPLS) |=> tf_reg == $past(chk_ls);
    endproperty
    a_cmpls: assert property (p_cmpls) else $error("lower-same flag wrong");

    property p_cmplti;
        s_issue(ACE_OP_CMPLTI) |=> tf_reg == $past(chk_lti);
    endproperty
    a_cmplti: assert property (p_cmplti) else $error("imm less-than flag wrong");

    property p_bad_hold;
        s_issue(ACE_OP_NONE) |=> reg_file[$past(dst_idx)] == $past(d_val);
    endproperty
    a_bad_hold: assert property (p_bad_hold) else $error("unknown opcode wrote register");

    // load port write lands when no instruction competes
    property p_load;
        load_en && !instr_valid |=> reg_file[$past(load_index)] == $past(load_data);
    endproperty
    a_load: assert property (p_load) else $error("load port write lost");

endmodule : alu_compare_execute

/* File: hw/ace_pkg.sv */
// ============================================================
// package for the conditional add, logic, shift and compare slice
// ============================================================
// Purpose: opcodes, field positions, operation codes and carriers
// Assumes: 16-bit instruction word, sixteen 32-bit registers
// Notes: shared by the execute top and its compute unit
package ace_pkg;

    // widths and field positions
    localparam int ACE_DATA_W = 32;
    localparam int ACE_REG_N = 16;
    localparam int ACE_OPC_HI = 15;
    localparam int ACE_OPC_LO = 8;
    localparam int ACE_DST_HI = 7;
    localparam int ACE_DST_LO = 4;
    localparam int ACE_LOW_HI = 3;
    localparam int ACE_LOW_LO = 0;
    localparam int ACE_SHAMT_W = 6;
    localparam logic [5:0] ACE_SHAMT_MAX = 6'h1F;
    localparam logic [31:0] ACE_REG_RESET = 32'h0000_0000;
    localparam logic ACE_TF_RESET = 1'h0;

    // opcode byte values, instruction bits 15..8
    localparam logic [7:0] ACE_OPC_ADDIT = 8'h3E;
    localparam logic [7:0] ACE_OPC_ADDT = 8'h3F;
    localparam logic [7:0] ACE_OPC_AND = 8'h25;
    localparam logic [7:0] ACE_OPC_ASRI = 8'h0F;
    localparam logic [7:0] ACE_OPC_CMPEQ = 8'h31;
    localparam logic [7:0] ACE_OPC_CMPEQI = 8'h30;
    localparam logic [7:0] ACE_OPC_CMPGT = 8'h35;
    localparam logic [7:0] ACE_OPC_CMPHS = 8'h32;
    localparam logic [7:0] ACE_OPC_CMPLS = 8'h33;
    localparam logic [7:0] ACE_OPC_CMPLT = 8'h34;
    localparam logic [7:0] ACE_OPC_ASR = 8'h0E;
    localparam logic [7:0] ACE_OPC_CMPGTI = 8'h37;
    localparam logic [7:0] ACE_OPC_CMPLTI = 8'h36;
    // and-immediate occupies a whole top nibble
    localparam logic [3:0] ACE_NIB_ANDI = 4'h5;

    // decoded operation
    typedef enum logic [3:0] {
        ACE_OP_NONE, ACE_OP_ADDIT, ACE_OP_ADDT, ACE_OP_AND, ACE_OP_ANDI,
        ACE_OP_ASR, ACE_OP_ASRI, ACE_OP_CMPEQ, ACE_OP_CMPEQI, ACE_OP_CMPGT,
        ACE_OP_CMPGTI, ACE_OP_CMPHS, ACE_OP_CMPLS, ACE_OP_CMPLT, ACE_OP_CMPLTI
    } ace_op_t;

    // instruction fields
    typedef struct packed {
        logic [7:0] opcode;
        logic [3:0] dst;
        logic [3:0] low;
    } ace_fields_t;

    // compute unit answer
    typedef struct packed {
        logic [31:0] value;
        logic wr;
        logic tf;
        logic tf_wr;
    } ace_alu_out_t;

endpackage : ace_pkg

/* File: hw/ace_alu.sv */
// Purpose: combinational compute for one decoded operation
// Assumes: operands already read from the register file
// Notes: no state; the top decides when results are stored
`timescale 1ns/100ps

module ace_alu (
    input wire ace_pkg::ace_op_t op,
    input wire logic [31:0] d_val,
    input wire logic [31:0] s_val,
    input wire logic [3:0] low,
    input wire logic [7:0] unsigned_imm_eight,
    input wire logic tf_in,
    output ace_pkg::ace_alu_out_t res
);
    import ace_pkg::*;

    // ============================================================
    // operand shaping
    // ============================================================
    // immediates and shifts
    wire logic [31:0] simm_ext = {{28{low[3]}}, low};
    wire logic [31:0] uimm_ext = {24'h000000, unsigned_imm_eight};
    wire logic [5:0] shamt = s_val[5:0];
    wire logic [31:0] asr_small = 32'($signed(d_val) >>> shamt[4:0]);
    wire logic [31:0] asr_dyn = (shamt > ACE_SHAMT_MAX) ? {32{d_val[31]}} : asr_small;
    wire logic [31:0] asr_imm = 32'($signed(d_val) >>> low);
    wire logic s_gt = $signed(d_val) > $signed(s_val);
    wire logic s_lt = $signed(d_val) < $signed(s_val);
    wire logic i_gt = $signed(d_val) > $signed(simm_ext);
    wire logic i_lt = $signed(d_val) < $signed(simm_ext);

    // ============================================================
    // operation select
    // ============================================================
    // value and write strobes per operation
    always_comb begin
        res = '0;
        case (op)
            ACE_OP_ADDIT: begin
                res.value = d_val + simm_ext;
                res.wr = tf_in;
            end
            ACE_OP_ADDT: begin
                res.value = d_val + s_val;
                res.wr = tf_in;
            end
            ACE_OP_AND: begin
                res.value = d_val & s_val;
                res.wr = 1'b1;
            end
            ACE_OP_ANDI: begin
                res.value = d_val & uimm_ext;
                res.wr = 1'b1;
            end
            ACE_OP_ASR: begin
                res.value = asr_dyn;
                res.wr = 1'b1;
            end
            ACE_OP_ASRI: begin
                res.value = asr_imm;
                res.wr = 1'b1;
            end
            ACE_OP_CMPEQ: begin
                res.tf = d_val == s_val;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPEQI: begin
                res.tf = d_val == simm_ext;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPGT: begin
                res.tf = s_gt;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPGTI: begin
                res.tf = i_gt;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPHS: begin
                res.tf = d_val >= s_val;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPLS: begin
                res.tf = d_val <= s_val;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPLT: begin
                res.tf = s_lt;
                res.tf_wr = 1'b1;
            end
            ACE_OP_CMPLTI: begin
                res.tf = i_lt;
                res.tf_wr = 1'b1;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule : ace_alu

/* File: dv/tb.sv */
// Purpose: self-checking bench for the add, and, shift and compare execute block
// Assumes: registers preloaded through the load port, read back through the read port
// Notes: each scenario compares registers or the flag; all but t_reset drive instructions
`timescale 1ns/100ps

module tb;
    import ace_pkg::*;

    logic clock, nrst, instr_valid, load_en, true_false_flag, done, illegal;
    logic [15:0] instr;
    logic [3:0] load_index, read_index;
    logic [31:0] load_data, read_data;
    int err_count, tests_run;
    int cycles = 0;

    alu_compare_execute u_dut (.clock(clock), .nrst(nrst), .instr_valid(instr_valid),
        .instr(instr), .load_en(load_en), .load_index(load_index), .load_data(load_data),
        .read_index(read_index), .read_data(read_data), .true_false_flag(true_false_flag),
        .done(done), .illegal(illegal));

    // ============================================================
    // clock and hang guard
    // ============================================================
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // cuts a hung run short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            test_done();
        end
    end

    // ============================================================
    // shared tasks
    // ============================================================
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic flag(input logic exp);
        chk("flag", {31'h0, exp}, {31'h0, true_false_flag});
    endtask : flag

    task automatic ld(input logic [3:0] idx, input logic [31:0] val);
        @(posedge clock);
        load_en <= 1'b1;
        load_index <= idx;
        load_data <= val;
        @(posedge clock);
        load_en <= 1'b0;
    endtask : ld

    // read data lands one edge after the index, wait two to be safe
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string name);
        @(posedge clock);
        read_index <= idx;
        repeat (2) @(posedge clock);
        #1;
        chk(name, exp, read_data);
    endtask : rd

    // one instruction; ok says whether it should be accepted
    task automatic ex(input logic [15:0] w, input logic ok);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        chk("done", {31'h0, ok}, {31'h0, done});
        chk("illegal", {31'h0, ~ok}, {31'h0, illegal});
    endtask : ex

    task automatic cmp(input logic [7:0] opc, input logic [3:0] lo, input logic [31:0] a,
                       input logic [31:0] b, input logic exp);
        ld(4'h7, a);
        ld(4'h8, b);
        ex({opc, 4'h7, lo}, 1'b1);
        flag(exp);
    endtask : cmp

    task automatic sh(input logic [31:0] amt, input logic [31:0] a, input logic [31:0] exp);
        ld(4'h5, a);
        ld(4'h6, amt);
        ex({ACE_OPC_ASR, 4'h5, 4'h6}, 1'b1);
        rd(4'h5, exp, "asr");
    endtask : sh

    // ============================================================
    // scenarios
    // ============================================================
    task automatic t_reset;
        rd(4'h0, 32'h0000_0000, "reset r0");
        flag(1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_add;
        ld(4'h1, 32'h0000_0005);
        ld(4'h2, 32'h0000_0007);
        ex({ACE_OPC_CMPEQ, 8'h12}, 1'b1);
        ex({ACE_OPC_ADDIT, 8'h1F}, 1'b1);
        ex({ACE_OPC_ADDT, 8'h12}, 1'b1);
        rd(4'h1, 32'h0000_0005, "add flag clear");
        ex({ACE_OPC_CMPEQ, 8'h11}, 1'b1);
        ex({ACE_OPC_ADDIT, 8'h18}, 1'b1);
        rd(4'h1, 32'hFFFF_FFFD, "addit");
        ex({ACE_OPC_ADDT, 8'h12}, 1'b1);
        rd(4'h1, 32'h0000_0004, "addt");
        flag(1'b1);
        $display("test add done");
    endtask : t_add

    task automatic t_logic;
        ld(4'h3, 32'hF0F0_A5A5);
        ld(4'h4, 32'h0FF0_FFFF);
        ex({ACE_OPC_AND, 8'h34}, 1'b1);
        rd(4'h3, 32'h00F0_A5A5, "and");
        ex(16'h533C, 1'b1);
        rd(4'h3, 32'h0000_0024, "andi");
        ld(4'h3, 32'hFFFF_FFFF);
        ex(16'h5F3F, 1'b1);
        rd(4'h3, 32'h0000_00FF, "andi max");
        flag(1'b1);
        $display("test logic done");
    endtask : t_logic

    task automatic t_shift;
        sh(32'h0000_0004, 32'h8000_0010, 32'hF800_0001);
        sh(32'hFFFF_FFC3, 32'h7000_0000, 32'h0E00_0000);
        sh(32'h0000_001F, 32'h8000_0000, 32'hFFFF_FFFF);
        sh(32'h0000_0020, 32'h8000_0010, 32'hFFFF_FFFF);
        sh(32'h0000_003F, 32'h7FFF_FFFF, 32'h0000_0000);
        sh(32'h0000_0040, 32'h8000_0010, 32'h8000_0010);
        ld(4'h5, 32'h8000_0000);
        ex({ACE_OPC_ASRI, 8'h5F}, 1'b1);
        rd(4'h5, 32'hFFFF_0000, "asri 15");
        ex({ACE_OPC_ASRI, 8'h50}, 1'b1);
        rd(4'h5, 32'hFFFF_0000, "asri 0");
        flag(1'b1);
        $display("test shift done");
    endtask : t_shift

    task automatic t_cmp;
        cmp(ACE_OPC_CMPEQ, 4'h8, 32'h5, 32'h5, 1'b1);
        cmp(ACE_OPC_CMPEQ, 4'h8, 32'h5, 32'h6, 1'b0);
        cmp(ACE_OPC_CMPEQI, 4'h8, 32'hFFFF_FFF8, 32'h0, 1'b1);
        cmp(ACE_OPC_CMPEQI, 4'h8, 32'h0000_0008, 32'h0, 1'b0);
        cmp(ACE_OPC_CMPGT, 4'h8, 32'h1, 32'hFFFF_FFFF, 1'b1);
        cmp(ACE_OPC_CMPGT, 4'h8, 32'hFFFF_FFFF, 32'h1, 1'b0);
        cmp(ACE_OPC_CMPGTI, 4'h8, 32'h0, 32'h0, 1'b1);
        cmp(ACE_OPC_CMPGTI, 4'hF, 32'hFFFF_FFFF, 32'h0, 1'b0);
        cmp(ACE_OPC_CMPHS, 4'h8, 32'hFFFF_FFFF, 32'h1, 1'b1);
        cmp(ACE_OPC_CMPHS, 4'h8, 32'h3, 32'h3, 1'b1);
        cmp(ACE_OPC_CMPHS, 4'h8, 32'h2, 32'h3, 1'b0);
        cmp(ACE_OPC_CMPLS, 4'h8, 32'h1, 32'hFFFF_FFFF, 1'b1);
        cmp(ACE_OPC_CMPLS, 4'h8, 32'h4, 32'h3, 1'b0);
        cmp(ACE_OPC_CMPLT, 4'h8, 32'hFFFF_FFFF, 32'h1, 1'b1);
        cmp(ACE_OPC_CMPLT, 4'h8, 32'h3, 32'h3, 1'b0);
        cmp(ACE_OPC_CMPLTI, 4'h8, 32'hFFFF_FFF7, 32'h0, 1'b1);
        cmp(ACE_OPC_CMPLTI, 4'h8, 32'hFFFF_FFF8, 32'h0, 1'b0);
        rd(4'h7, 32'hFFFF_FFF8, "cmp keeps reg");
        $display("test compare done");
    endtask : t_cmp

    task automatic t_illegal;
        ld(4'h9, 32'h0000_1234);
        ex({ACE_OPC_CMPEQ, 8'h90}, 1'b1);
        ex(16'hFF99, 1'b0);
        flag(1'b0);
        rd(4'h9, 32'h0000_1234, "illegal keeps reg");
        $display("test illegal done");
    endtask : t_illegal

    // second instruction sees the flag the first one set
    task automatic t_b2b;
        ld(4'hA, 32'h0000_0010);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= {ACE_OPC_CMPGTI, 8'hA8};
        load_en <= 1'b1;
        load_index <= 4'hB;
        load_data <= 32'hFFFF_FFFF;
        @(posedge clock);
        instr <= {ACE_OPC_ADDIT, 8'hA7};
        @(posedge clock);
        instr_valid <= 1'b0;
        load_en <= 1'b0;
        rd(4'hA, 32'h0000_0017, "back to back");
        rd(4'hB, 32'h0000_0000, "load refused");
        $display("test back to back done");
    endtask : t_b2b

    // ============================================================
    // verdict
    // ============================================================
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // reset, then run every scenario in turn
    initial begin
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        load_en = 1'b0;
        load_index = 4'h0;
        load_data = 32'h0000_0000;
        read_index = 4'h0;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_add();
        t_logic();
        t_shift();
        t_cmp();
        t_illegal();
        t_b2b();
        test_done();
    end

endmodule : tb
